// ---- logic/sas_sequencer.sv ----
/*
 * converter sequencer: control registers, sample/convert sequence, input
 * mux selection, 32-word result store and interrupt pacing. assumes the
 * analog core answers a start pulse with a one-cycle done and result, and
 * that all inputs are synchronous to i_mclk.
 */
// Our own choices: the strobed register port and the address map.
`include "sas_defines.svh"

module sas_sequencer (
	input  wire logic                   i_mclk,
	input  wire logic                   i_reset,
	input  wire logic [`SAS_ADDR_W-1:0] i_addr,
	input  wire logic [15:0]            i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [15:0]            o_rdata,
	input  wire logic                   i_idle,
	input  wire logic                   i_rc_tick,
	input  wire logic                   i_timer3_match,
	input  wire logic                   i_timer5_match,
	input  wire logic                   i_charge_time_unit,
	input  wire logic                   i_external_interrupt_zero,
	input  wire logic                   i_conv_done,
	input  wire logic [9:0]             i_conv_result,
	output logic                        o_sample,
	output logic                        o_conv_start,
	output logic      [4:0]             o_pos_channel,
	output logic                        o_neg_an1,
	output logic                        o_ref_pos_external,
	output logic                        o_ref_neg_external,
	output logic                        o_converter_interrupt
);
	sas_pkg::sas_state_t s;
	sas_pkg::sas_state_t next_s;
	logic [9:0]          mem [32];
	logic                mem_we;
	logic                active;
	logic                tick;
	logic                trig;
	logic [2:0]          trig_sel;
	logic                sample_active_clr;

	// next selected scan input after ptr, wrapping; ptr kept if none
	function automatic logic [4:0] next_scan(input logic [4:0] ptr,
		input logic [27:0] sel);
		logic [4:0] p;
		logic [4:0] r;
		logic       found;
		p = ptr;
		r = ptr;
		found = 1'b0;
		for (int k = 0; k < 28; k++)
		begin
			p = (p >= `SAS_LAST_SCAN) ? 5'h00 : 5'(p + 5'h01);
			if (!found && sel[p])
			begin
				r = p;
				found = 1'b1;
			end
		end
		return r;
	endfunction

	// present a raw result in the chosen layout
	function automatic logic [15:0] fmt(input logic [1:0] f, input logic [9:0] d);
		logic [15:0] r;
		r = 16'h0000;
		case (sas_pkg::sas_format_t'(f))
			sas_pkg::SAS_FMT_INT:   r = {6'h00, d};
			sas_pkg::SAS_FMT_SINT:  r = {{7{~d[9]}}, d[8:0]};
			sas_pkg::SAS_FMT_FRAC:  r = {d, 6'h00};
			sas_pkg::SAS_FMT_SFRAC: r = {~d[9], d[8:0], 6'h00};
			default:                r = {6'h00, d};
		endcase
		return r;
	endfunction

	assign trig_sel = s.ctrl_one[7:5];
	assign active = s.ctrl_one[`SAS_B_ON] && !(s.ctrl_one[`SAS_B_IDLE_STOP] && i_idle);
	assign tick = s.ctrl_thr[`SAS_B_CLKSRC] ? i_rc_tick : (s.div_cnt == s.ctrl_thr[7:0]);
	assign sample_active_clr = i_wr && i_addr == `SAS_OFS_CTRL_ONE && !i_wdata[`SAS_B_SAMPLE_ACTIVE];

	always_comb
	begin
		case (trig_sel)
			`SAS_TRIG_SOFT: trig = sample_active_clr;
			`SAS_TRIG_EXTERNAL_INTERRUPT_ZERO: trig = i_external_interrupt_zero && !s.external_interrupt_zero_q;
			`SAS_TRIG_TMR3: trig = i_timer3_match;
			`SAS_TRIG_TMR5: trig = i_timer5_match;
			`SAS_TRIG_CHARGE_TIME_UNIT: trig = i_charge_time_unit;
			`SAS_TRIG_AUTO: trig = (s.sample_active_cnt >= s.ctrl_thr[12:8]);
			default:        trig = 1'b0;
		endcase
	end

	always_comb
	begin
		next_s = s;
		next_s.start_conv = 1'b0;
		next_s.irq = 1'b0;
		next_s.external_interrupt_zero_q = i_external_interrupt_zero;
		mem_we = 1'b0;
		next_s.div_cnt = (tick || !active) ? 8'h00 : 8'(s.div_cnt + 8'h01);

		if (i_wr)
		begin
			case (i_addr)
				`SAS_OFS_CTRL_ONE:
					next_s.ctrl_one = (i_wdata & `SAS_WMASK_ONE)
						| (s.ctrl_one & ~`SAS_WMASK_ONE);
				`SAS_OFS_CTRL_TWO:
					next_s.ctrl_two = (i_wdata & `SAS_WMASK_TWO)
						| (s.ctrl_two & ~`SAS_WMASK_TWO);
				`SAS_OFS_CTRL_THR:
					next_s.ctrl_thr = i_wdata & `SAS_WMASK_THR;
				`SAS_OFS_CHSEL:
					next_s.chsel = i_wdata & `SAS_WMASK_CHSEL;
				`SAS_OFS_SCAN_LO:
					next_s.scan_sel[15:0] = i_wdata;
				`SAS_OFS_SCAN_HI:
					next_s.scan_sel[27:16] = 12'(i_wdata & `SAS_WMASK_SCAN_HI);
				default:
					next_s.rdata = next_s.rdata;
			endcase
		end

		if (s.alt_b)
		begin
			next_s.chan = s.chsel[12:8];
			next_s.neg_an1 = s.chsel[`SAS_B_NEG_B];
		end
		else
		begin
			next_s.chan = s.ctrl_two[`SAS_B_SCAN] ? s.scan_ptr : s.chsel[4:0];
			next_s.neg_an1 = s.chsel[`SAS_B_NEG_A];
		end

		if (!next_s.ctrl_one[`SAS_B_ON])
		begin
			next_s.valid = 32'h0000_0000;
			next_s.phase = sas_pkg::SAS_IDLE;
			next_s.ctrl_one[`SAS_B_SAMPLE_ACTIVE] = 1'b0;
			next_s.wr_ptr = 5'h00;
			next_s.seq_cnt = 5'h00;
			next_s.ctrl_two[`SAS_B_FILL] = 1'b0;
			next_s.alt_b = 1'b0;
			next_s.scan_ptr = next_scan(`SAS_LAST_SCAN, s.scan_sel);
		end
		else if (active)
		begin
			case (s.phase)
				sas_pkg::SAS_IDLE:
				begin
					if (next_s.ctrl_one[`SAS_B_SAMPLE_ACTIVE])
					begin
						next_s.phase = sas_pkg::SAS_SAMPLE;
						next_s.sample_active_cnt = 5'h00;
					end
				end
				sas_pkg::SAS_SAMPLE:
				begin
					if (tick && s.sample_active_cnt != 5'h1F)
						next_s.sample_active_cnt = 5'(s.sample_active_cnt + 5'h01);
					if (trig_sel != `SAS_TRIG_SOFT && !next_s.ctrl_one[`SAS_B_SAMPLE_ACTIVE])
						next_s.phase = sas_pkg::SAS_IDLE;
					else if (trig)
					begin
						next_s.ctrl_one[`SAS_B_SAMPLE_ACTIVE] = 1'b0;
						next_s.ctrl_one[`SAS_B_DONE] = 1'b0;
						next_s.start_conv = 1'b1;
						next_s.phase = sas_pkg::SAS_CONVERT;
					end
				end
				sas_pkg::SAS_CONVERT:
				begin
					next_s.ctrl_one[`SAS_B_SAMPLE_ACTIVE] = 1'b0;
					if (i_conv_done)
					begin
						next_s.ctrl_one[`SAS_B_DONE] = 1'b1;
						mem_we = 1'b1;
						next_s.valid[s.wr_ptr] = 1'b1;
						if (s.ctrl_two[`SAS_B_SCAN] && !s.alt_b)
							next_s.scan_ptr = next_scan(s.scan_ptr, s.scan_sel);
						if (s.ctrl_two[`SAS_B_ALTERNATE_SAMPLE])
							next_s.alt_b = !s.alt_b;
						if (s.seq_cnt == s.ctrl_two[6:2])
						begin
							next_s.irq = 1'b1;
							next_s.seq_cnt = 5'h00;
							next_s.alt_b = 1'b0;
							next_s.scan_ptr = next_scan(`SAS_LAST_SCAN, s.scan_sel);
							if (s.ctrl_two[`SAS_B_BUFFER_MODE])
							begin
								next_s.ctrl_two[`SAS_B_FILL] = !s.ctrl_two[`SAS_B_FILL];
								next_s.wr_ptr = {!s.ctrl_two[`SAS_B_FILL], 4'h0};
							end
							else
							begin
								next_s.wr_ptr = 5'h00;
							end
						end
						else
						begin
							next_s.seq_cnt = 5'(s.seq_cnt + 5'h01);
							if (s.ctrl_two[`SAS_B_BUFFER_MODE])
								next_s.wr_ptr = {s.wr_ptr[4], 4'(s.wr_ptr[3:0] + 4'h1)};
							else
								next_s.wr_ptr = 5'(s.wr_ptr + 5'h01);
						end
						if (s.ctrl_one[`SAS_B_AUTO])
						begin
							next_s.ctrl_one[`SAS_B_SAMPLE_ACTIVE] = 1'b1;
							next_s.sample_active_cnt = 5'h00;
							next_s.phase = sas_pkg::SAS_SAMPLE;
						end
						else
						begin
							next_s.phase = sas_pkg::SAS_IDLE;
						end
					end
				end
				default:
					next_s.phase = sas_pkg::SAS_IDLE;
			endcase
		end

		// read data, one cycle after the strobe
		next_s.rdata = 16'h0000;
		if (i_rd)
		begin
			if (i_addr >= `SAS_OFS_BUF_BASE)
			begin
				if (s.valid[i_addr[4:0]])
					next_s.rdata = fmt(s.ctrl_one[9:8], mem[i_addr[4:0]]);
			end
			else
			begin
				case (i_addr)
					`SAS_OFS_CTRL_ONE: next_s.rdata = s.ctrl_one;
					`SAS_OFS_CTRL_TWO: next_s.rdata = s.ctrl_two;
					`SAS_OFS_CTRL_THR: next_s.rdata = s.ctrl_thr;
					`SAS_OFS_CHSEL:    next_s.rdata = s.chsel;
					`SAS_OFS_SCAN_LO:  next_s.rdata = s.scan_sel[15:0];
					`SAS_OFS_SCAN_HI:  next_s.rdata = {4'h0, s.scan_sel[27:16]};
					default:           next_s.rdata = 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			s <= '0;
		else
			s <= next_s;
	end

	always_ff @(posedge i_mclk)
	begin
		if (mem_we)
			mem[s.wr_ptr] <= i_conv_result;
	end

	assign o_rdata = s.rdata;
	assign o_sample = s.ctrl_one[`SAS_B_SAMPLE_ACTIVE] && s.phase == sas_pkg::SAS_SAMPLE;
	assign o_conv_start = s.start_conv;
	assign o_pos_channel = s.chan;
	assign o_neg_an1 = s.neg_an1;
	assign o_ref_pos_external = !s.ctrl_two[15] && s.ctrl_two[13];
	assign o_ref_neg_external = !s.ctrl_two[15] && s.ctrl_two[14];
	assign o_converter_interrupt = s.irq;
endmodule

// ---- logic/sas_defines.svh ----
/*
 * offsets, field positions, write masks and reset values of the converter
 * sequencer. assumes a word-indexed register port, one register per index.
 */
// How it works
// - module-on bit runs or stops the converter
// - switching off discards buffered results
// - idle-stop bit halts converter during idle
// - output-format field picks four result layouts
// - trigger codes 111, 110, 100; 101 and 011 reserved
// - trigger codes 010, 001, 000 end sampling
// - auto-sample restarts sampling, sets sample-active bit
// - without auto-sample, sampling waits for software
// - sample-active reads 1 acquiring, 0 holding
// - done bit set when conversion finishes
// - reference-select picks supplies or external pins
// - scan-enable steps mux A positive input
// - fill status shows half being filled
// - interrupt after every N+1 sequences
// - buffer mode: one 32 or two 16
// - alternate-sample swaps mux B and mux A
// - mux addresses inputs 0-23 plus references
// - auto-sample time 0 to 31 periods
// - conversion clock is value+1 system cycles
// - clock-source bit selects internal RC clock
// - scan visits only selected inputs
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

`define SAS_ADDR_W        6
`define SAS_OFS_CTRL_ONE  6'h00
`define SAS_OFS_CTRL_TWO  6'h01
`define SAS_OFS_CTRL_THR  6'h02
`define SAS_OFS_CHSEL     6'h03
`define SAS_OFS_SCAN_LO   6'h04
`define SAS_OFS_SCAN_HI   6'h05
`define SAS_OFS_BUF_BASE  6'h20

`define SAS_WMASK_ONE     16'hA3E6
`define SAS_WMASK_TWO     16'hE47F
`define SAS_WMASK_THR     16'h9FFF
`define SAS_WMASK_CHSEL   16'h9F9F
`define SAS_WMASK_SCAN_HI 16'h0FFF
`define SAS_RESET_REG     16'h0000

`define SAS_B_ON          15
`define SAS_B_IDLE_STOP   13
`define SAS_B_AUTO        2
`define SAS_B_SAMPLE_ACTIVE        1
`define SAS_B_DONE        0
`define SAS_B_SCAN        10
`define SAS_B_FILL        7
`define SAS_B_BUFFER_MODE        1
`define SAS_B_ALTERNATE_SAMPLE        0
`define SAS_B_CLKSRC      15
`define SAS_B_NEG_B       15
`define SAS_B_NEG_A       7

`define SAS_TRIG_SOFT     3'h0
`define SAS_TRIG_EXTERNAL_INTERRUPT_ZERO     3'h1
`define SAS_TRIG_TMR3     3'h2
`define SAS_TRIG_TMR5     3'h4
`define SAS_TRIG_CHARGE_TIME_UNIT     3'h6
`define SAS_TRIG_AUTO     3'h7

`define SAS_LAST_SCAN     5'h1B
`endif

// ---- logic/sas_pkg.sv ----
/*
 * types of the converter sequencer: sequence phase, result format and
 * the one packed state record. assumes sas_defines.svh for field widths.
 */
package sas_pkg;
	typedef enum logic [1:0] {
		SAS_IDLE,
		SAS_SAMPLE,
		SAS_CONVERT
	} sas_phase_t;

	typedef enum logic [1:0] {
		SAS_FMT_INT,
		SAS_FMT_SINT,
		SAS_FMT_FRAC,
		SAS_FMT_SFRAC
	} sas_format_t;

	typedef struct packed {
		logic [15:0] ctrl_one;
		logic [15:0] ctrl_two;
		logic [15:0] ctrl_thr;
		logic [15:0] chsel;
		logic [27:0] scan_sel;
		sas_phase_t  phase;
		logic [7:0]  div_cnt;
		logic [4:0]  sample_active_cnt;
		logic [4:0]  seq_cnt;
		logic [4:0]  wr_ptr;
		logic [4:0]  scan_ptr;
		logic        alt_b;
		logic        external_interrupt_zero_q;
		logic [31:0] valid;
		logic [15:0] rdata;
		logic        start_conv;
		logic        irq;
		logic [4:0]  chan;
		logic        neg_an1;
	} sas_state_t;
endpackage

// ---- dv/sas_sequencer_monitor.sv ----
/* port assertions of the converter sequencer.
   bound to sas_sequencer; sees its ports only. */
module sas_sequencer_monitor (
	input wire logic        i_mclk,
	input wire logic        i_reset,
	input wire logic [5:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        i_idle,
	input wire logic        i_conv_done,
	input wire logic        o_sample,
	input wire logic        o_conv_start,
	input wire logic        o_ref_pos_external,
	input wire logic        o_ref_neg_external,
	input wire logic        o_converter_interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] c1;
	logic [15:0] c2;
	logic        halt;
	assign halt = !c1[15] || (c1[13] && i_idle);
	// shadow of the two control words
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			c1 <= 16'h0000;
			c2 <= 16'h0000;
		end
		else if (i_wr && i_addr == 6'h00)
			c1 <= i_wdata;
		else if (i_wr && i_addr == 6'h01)
			c2 <= i_wdata;
	end
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	property p_halt; $past(halt) |-> !o_conv_start; endproperty
	a_halt: assert property (p_halt) else $error("start while halted");
	property p_sample_active_rd; i_rd && i_addr == 6'h00 |=> o_rdata[1] == $past(o_sample); endproperty
	a_sample_active_rd: assert property (p_sample_active_rd) else $error("sample bit mismatch");
	property p_hold; o_conv_start |-> !o_sample; endproperty
	a_hold: assert property (p_hold) else $error("sampling during start");
	property p_gap; o_conv_start |=> !o_conv_start [*2]; endproperty
	a_gap: assert property (p_gap) else $error("start not a pulse");
	property p_refp; o_ref_pos_external == (c2[15:13] == 3'h1 || c2[15:13] == 3'h3); endproperty
	a_refp: assert property (p_refp) else $error("positive ref wrong");
	property p_refn; o_ref_neg_external == (c2[15:13] == 3'h2 || c2[15:13] == 3'h3); endproperty
	a_refn: assert property (p_refn) else $error("negative ref wrong");
	property p_soft;
		i_wr && i_addr == 6'h00 && i_wdata[15] && i_wdata[7:5] == 3'h0 && !i_wdata[1]
			&& o_sample && c1[7:5] == 3'h0 && !halt |=> o_conv_start;
	endproperty
	a_soft: assert property (p_soft) else $error("software trigger lost");
	property p_resv; $past(c1[7:5] == 3'h3 || c1[7:5] == 3'h5) |-> !o_conv_start; endproperty
	a_resv: assert property (p_resv) else $error("reserved code triggered");
	property p_irq_src; o_converter_interrupt |-> $past(i_conv_done); endproperty
	a_irq_src: assert property (p_irq_src) else $error("interrupt without result");
	property p_irq_one; i_conv_done && c2[6:2] == 5'h00 && !halt |=> o_converter_interrupt; endproperty
	a_irq_one: assert property (p_irq_one) else $error("interrupt missing");
	c_auto: cover property (o_conv_start && c1[2]);
	c_split: cover property (o_converter_interrupt && c2[1]);
	c_idle: cover property (c1[15] && c1[13] && i_idle);
endmodule

bind sas_sequencer sas_sequencer_monitor u_monitor (
	.i_mclk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_idle, .i_conv_done,
	.o_sample, .o_conv_start, .o_ref_pos_external, .o_ref_neg_external, .o_converter_interrupt
);

// ---- dv/sas_core_model.sv ----
/* behavioural analog core: one done pulse per start.
   assumes a one-cycle start in the i_mclk domain. */
module sas_core_model (
	input  wire logic       i_mclk,
	input  wire logic       i_reset,
	input  wire logic       i_start,
	input  wire logic       i_slow,
	output logic            o_done,
	output logic      [9:0] o_result
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_cnt;
	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wait_cnt <= 0;
			o_done <= 1'b0;
			o_result <= 10'h000;
		end
		else
		begin
			// result lines never hold a stale value
			o_result <= o_result + 10'h0DB;
			o_done <= wait_cnt == 1;
			if (i_start)
				wait_cnt <= i_slow ? 9 : 2;
			else if (wait_cnt > 0)
				wait_cnt <= wait_cnt - 1;
		end
	end
endmodule

// ---- dv/sas_sequencer_bench.sv ----
/* self-checking bench of the converter sequencer.
   assumes sas_core_model as analog core. */
module sas_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        rst;
	logic [5:0]  addr;
	logic [15:0] wdata;
	logic        wr_s;
	logic        rd_s;
	logic        idle;
	logic        rc;
	logic        t3;
	logic        t5;
	logic        charge_time_unit;
	logic        external_interrupt_zero;
	logic        slow;
	logic        done;
	logic [9:0]  res;
	logic [15:0] rdata;
	logic        sample_active;
	logic        start;
	logic [4:0]  pos;
	logic        neg;
	logic        irq;
	logic [15:0] exp_buf [32];
	int          tc [6] = '{1, 2, 4, 6, 3, 5};
	int          failures, total_checks, wp, n, half, alt_b, sequences_per_interrupt, buffer_mode, alternate_sample, fmt;
	int          posa, posb, starts, irqs, due, s0, seed, e_ch, sel, scan, si;
	int          scan_q [$];

	sas_sequencer dut (.i_mclk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_idle(idle), .i_rc_tick(rc),
		.i_timer3_match(t3), .i_timer5_match(t5), .i_charge_time_unit(charge_time_unit),
		.i_external_interrupt_zero(external_interrupt_zero), .i_conv_done(done), .i_conv_result(res),
		.o_sample(sample_active), .o_conv_start(start), .o_pos_channel(pos), .o_neg_an1(neg),
		.o_ref_pos_external(), .o_ref_neg_external(), .o_converter_interrupt(irq));
	sas_core_model core (.i_mclk(clk), .i_reset(rst), .i_start(start), .i_slow(slow),
		.o_done(done), .o_result(res));

	function automatic logic [15:0] shape(input logic [9:0] r, input int f);
		case (f)
			0: return {6'h00, r};
			1: return {{7{~r[9]}}, r[8:0]};
			2: return {r, 6'h00};
			default: return {~r[9], r[8:0], 6'h00};
		endcase
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic summarize();
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [15:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk(nm, e, rdata);
	endtask

	task automatic cfg(input logic [15:0] v);
		sequences_per_interrupt = v[6:2];
		buffer_mode = v[1];
		alternate_sample = v[0];
		scan = v[10];
		si = 0;
		n = 0;
		wp = 0;
		half = 0;
		alt_b = 0;
		exp_buf = '{default: 16'h0000};
		wr(6'h01, v);
	endtask

	task automatic wait_irq(input int t);
		repeat (1000)
			if (irqs < t)
				@(posedge clk);
		chk("irq_count", 16'(t), 16'(irqs));
	endtask

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk)
		rc <= 1'($random(seed));

	// reference model of store, pacing and mux choice
	always @(posedge clk)
		if (!rst)
		begin
			chk("irq", 16'(due), 16'(irq));
			due = 0;
			irqs += irq;
			if (start)
			begin
				e_ch = alt_b ? posb : scan ? scan_q[si % scan_q.size()] : posa;
				chk("chan", 16'(e_ch), 16'(pos));
				if (!alt_b)
					si += scan;
				alt_b ^= alternate_sample;
				starts++;
			end
			if (done)
			begin
				exp_buf[half * 16 + wp] = shape(res, fmt);
				wp++;
				n++;
				if (n == sequences_per_interrupt + 1)
				begin
					due = 1;
					n = 0;
					wp = 0;
					alt_b = 0;
					si = 0;
					half ^= buffer_mode;
				end
			end
		end

	initial
	begin
		#(25 * 20000);
		failures++;
		summarize();
	end

	initial
	begin
		seed = 10;
		{addr, wdata, wr_s, rd_s, idle, rc, t3, t5, charge_time_unit, external_interrupt_zero, slow} = '0;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++)
			rd(6'(i), 16'h0000, "reset");
		wr(6'h01, 16'hEFFF);
		rd(6'h01, 16'hE47F, "ctrl_two");
		wr(6'h00, 16'h7FFD);
		rd(6'h00, 16'h23E4, "ctrl_one");
		wr(6'h06, 16'hFFFF);
		rd(6'h06, 16'h0000, "unmapped");
		for (int v = 0; v < 8; v++)
			wr(6'h01, 16'(v << 13));
		posa = $unsigned($random(seed)) % 24;
		posb = $unsigned($random(seed)) % 24;
		wr(6'h03, 16'(posb << 8 | posa) | 16'h0080);
		cfg(16'h0000);
		for (int f = 0; f < 4; f++)
		begin
			fmt = f;
			wr(6'h00, 16'(f << 8) | 16'h8002);
			repeat (3) @(posedge clk);
			wr(6'h00, 16'(f << 8) | 16'h8000);
			wait_irq(irqs + 1);
			rd(6'h20, exp_buf[0], "result");
			rd(6'h00, 16'(f << 8) | 16'h8001, "done");
		end
		chk("neg", 16'h0001, 16'(neg));
		for (int k = 0; k < 6; k++)
		begin
			s0 = starts;
			wr(6'h00, 16'(tc[k] << 5) | 16'h8002);
			repeat (2) @(posedge clk);
			{external_interrupt_zero, t3, t5, charge_time_unit} <= k > 3 ? 4'hF : {tc[k] == 1, tc[k] == 2, tc[k] == 4, tc[k] == 6};
			@(posedge clk);
			{external_interrupt_zero, t3, t5, charge_time_unit} <= 4'h0;
			repeat (12) @(posedge clk);
			chk("trigger", 16'(k < 4), 16'(starts - s0));
		end
		wr(6'h00, 16'h0000);
		rd(6'h20, 16'h0000, "cleared");
		cfg(16'h0409);
		fmt = 0;
		sel = $random(seed) | 1;
		for (int i = 0; i < 16; i++)
			if (sel[i])
				scan_q.push_back(i);
		wr(6'h04, 16'(sel));
		wr(6'h00, 16'h80E6);
		wait_irq(irqs + 2);
		wr(6'h00, 16'h80E0);
		repeat (12) @(posedge clk);
		wr(6'h00, 16'h0000);
		cfg(16'h000B);
		slow <= 1'b1;
		wr(6'h02, 16'h8500);
		wr(6'h00, 16'hA0E6);
		wait_irq(irqs + 3);
		idle <= 1'b1;
		s0 = starts;
		repeat (40) @(posedge clk);
		chk("halt", 16'h0000, 16'(starts - s0));
		rd(6'h01, 16'h000B | 16'(half << 7), "fill");
		for (int i = 0; i < 32; i++)
			rd(6'(32 + i), exp_buf[i], "buffer");
		@(posedge clk);
		idle <= 1'b0;
		s0 = starts;
		repeat (60) @(posedge clk);
		chk("auto", 16'h0001, 16'(starts > s0));
		wr(6'h00, 16'h0000);
		summarize();
	end
endmodule
